// file: rtl/csrs_defines.svh
// Register offsets, field positions, reset values and timing counts of the clock security block
`ifndef CSRS_DEFINES_SVH
`define CSRS_DEFINES_SVH

// ==========================================================
// Register indices and byte addresses
`define CSRS_STATUS_IDX        8'h25
`define CSRS_STATUS_ADDR       8'h94
`define CSRS_MISC1_IDX         8'h20
`define CSRS_MISC1_ADDR        8'h80

// ==========================================================
// Status register fields
`define CSRS_ST_WDG_BIT        0
`define CSRS_ST_BACKUP_BIT     1
`define CSRS_ST_IRQEN_BIT      2
`define CSRS_ST_SUPPLY_BIT     4

// ==========================================================
// First miscellaneous control register fields
`define CSRS_MC_CLKOUT_BIT     0
`define CSRS_MC_SLOW_BIT       1
`define CSRS_MC_DIVLO_BIT      3
`define CSRS_MC_DIVHI_BIT      4
`define CSRS_MISC1_RESET       5'h00

// ==========================================================
// Bus answers
`define CSRS_RESP_OKAY         2'h0
`define CSRS_RESP_SLVERR       2'h2

// ==========================================================
// Timing: one backup oscillator period, and its count at 25 ns per cycle
`define CSRS_CLK_PERIOD_NS     25
`define CSRS_BACKUP_PERIOD_NS  4000
`define CSRS_BACKUP_CYC \
  ((`CSRS_BACKUP_PERIOD_NS + `CSRS_CLK_PERIOD_NS - 1) / `CSRS_CLK_PERIOD_NS)

`endif

// file: rtl/csrs_pkg.sv
// Types shared by the clock security block
package csrs_pkg;

  // ==========================================================
  // Main oscillator choice from the option setting
  typedef enum logic [2:0] {
    CSRS_OSC_RES0    = 3'h0,
    CSRS_OSC_RES1    = 3'h1,
    CSRS_OSC_RES2    = 3'h2,
    CSRS_OSC_RES3    = 3'h3,
    CSRS_OSC_EXT_RC  = 3'h4,
    CSRS_OSC_INT_RC  = 3'h5,
    CSRS_OSC_EXT_CLK = 3'h6
  } csrs_osc_t;

  // ==========================================================
  // Supervision states
  typedef enum logic [2:0] {
    CSRS_SUP_MAIN   = 3'h1,
    CSRS_SUP_LOST   = 3'h2,
    CSRS_SUP_BACKUP = 3'h4
  } csrs_sup_t;

endpackage : csrs_pkg

// file: rtl/csrs_prescaler.sv
// CPU clock prescaler: divide by 2, or by 4/8/16/32 in slow mode
module csrs_prescaler (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       srst,
  // Control
  input  wire logic       slowMode,
  input  wire logic [1:0] slowDivSel,
  // Divided clock
  output logic            cpuClk,
  output logic            cpuTick
);

  logic [3:0] halfCnt_r;
  logic [3:0] halfLast;
  logic       cpuClk_r;
  logic       cpuTick_r;

  // Half period minus one: normal 0 cycles, slow 1/3/7/15 cycles
  always_comb begin
    halfLast = 4'h0;
    if (slowMode) begin
      unique case (slowDivSel)
        2'h0: halfLast = 4'h1;
        2'h1: halfLast = 4'h3;
        2'h2: halfLast = 4'h7;
        2'h3: halfLast = 4'hF;
      endcase
    end
  end

  // A new selection takes effect in the running half period, which never ends shorter than the new setting, so no runt pulse
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      halfCnt_r <= 4'h0;
      cpuClk_r  <= 1'b0;
      cpuTick_r <= 1'b0;
    end else if (halfCnt_r >= halfLast) begin
      halfCnt_r <= 4'h0;
      cpuClk_r  <= ~cpuClk_r;
      cpuTick_r <= ~cpuClk_r;
    end else begin
      halfCnt_r <= halfCnt_r + 4'h1;
      cpuTick_r <= 1'b0;
    end
  end

  assign cpuClk  = cpuClk_r;
  assign cpuTick = cpuTick_r;

endmodule : csrs_prescaler

// file: rtl/csrs_clock_security.sv
// Clock supervision, reset cause flags, CPU clock prescaling and clock output
//
// Summary of operation
// - Resonator oscillator keeps running through reset
// - Option setting selects the active main oscillator
// - Option setting enables whole clock supervision
// - Filter harmonics; resume once source behaves
// - Clock lost one backup period: use backup
// - Return to main clock once it recovers
// - Backup flag set; read clears after recovery
// - Supervision disabled forces backup flag zero
// - Fail interrupt needs enable and cleared mask
// - Software owns enable; inert without supervision
// - Wait keeps supervision; fail interrupt wakes wait
// - Halt freezes backup flag and enable, stops supervision
// - Supply-drop flag set by hardware, written zero
// - Watchdog flag set; zero write or drop clears
// - Supply-drop flag survives later other resets
// - Prescaler steered by two select, one slow bit
// - Clock output bit drives CPU clock pin
// - Normal divide 2; slow 4/8/16/32
// - Slow bit set enables slow mode
`include "csrs_defines.svh"

module csrs_clock_security (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        srst,
  // AXI4-Lite register slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Non-volatile option pins
  input  wire logic [2:0]  optOscSel,
  input  wire logic        optSupervisionEn,
  input  wire logic        optSupplyDetEn,
  // Main clock sense pins
  input  wire logic        mainClkPresent,
  input  wire logic        mainClkHarmonic,
  // Reset cause pins
  input  wire logic        supplyDropReset,
  input  wire logic        watchdogReset,
  // CPU state, same clock
  input  wire logic        cpuIntMask,
  input  wire logic        cpuWaitState,
  input  wire logic        cpuHaltState,
  // Clock controls and status
  output logic [2:0]       oscSource_r,
  output logic             resonatorRun_r,
  output logic             clkFilterActive_r,
  output logic             backupClkSelect_r,
  output logic             clkFailIrq_r,
  output logic             clkFailWake_r,
  output logic             cpuClk,
  output logic             cpuClkTick,
  output logic             clkOutPin_r,
  output logic             clkOutPinOe_r
);

  // ==========================================================
  // Pin synchronisers
  localparam int SYNC_W = 9;
  logic [SYNC_W-1:0] pinRaw;
  logic [SYNC_W-1:0] pinMeta_r;
  logic [SYNC_W-1:0] pinSync_r;
  logic              dropDly_r;
  logic              wdgDly_r;

  assign pinRaw = {optOscSel, optSupervisionEn, optSupplyDetEn, mainClkPresent,
                   mainClkHarmonic, supplyDropReset, watchdogReset};

  // No reset: the option must reach its capture during srst, and a pin held
  // high across reset must not look like a fresh event once srst ends
  always_ff @(posedge ref_clk) begin
    pinMeta_r <= pinRaw;
    pinSync_r <= pinMeta_r;
    dropDly_r <= pinSync_r[1];
    wdgDly_r  <= pinSync_r[0];
  end

  wire logic [2:0] oscSelSync      = pinSync_r[8:6];
  wire logic       supEnSync       = pinSync_r[5];
  wire logic       supplyDetEnSync = pinSync_r[4];
  wire logic       clkPresentSync  = pinSync_r[3];
  wire logic       harmonicSync    = pinSync_r[2];
  wire logic       dropEvt         = pinSync_r[1] & ~dropDly_r;
  wire logic       wdgEvt          = pinSync_r[0] & ~wdgDly_r;

  // ==========================================================
  // Oscillator selection
  // The option is re-captured during every reset, so a changed strap takes effect there
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      oscSource_r <= oscSelSync;
    end
  end

  // Resonators stay on through reset: no start-up wait when it ends
  always_ff @(posedge ref_clk) begin
    resonatorRun_r <= (oscSelSync <= csrs_pkg::CSRS_OSC_RES3);
  end

  // ==========================================================
  // Clock supervision
  wire logic supActive = supEnSync & ~cpuHaltState;
  wire logic mainGood  = clkPresentSync & ~(supActive & harmonicSync);

  // Harmonic operation is filtered away entirely until it stops
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      clkFilterActive_r <= 1'b0;
    end else begin
      clkFilterActive_r <= supActive & harmonicSync;
    end
  end

  localparam logic [7:0] BACKUP_LAST = 8'(`CSRS_BACKUP_CYC - 1);
  csrs_pkg::csrs_sup_t supState_r;
  logic [7:0]          lostCnt_r;
  wire logic           enterBackup = supActive & (supState_r == csrs_pkg::CSRS_SUP_LOST)
                                     & ~mainGood & (lostCnt_r == BACKUP_LAST);

  // Halt holds the state so the previous configuration resumes on an interrupt wake
  always_ff @(posedge ref_clk) begin
    if (srst || !supEnSync) begin
      supState_r <= csrs_pkg::CSRS_SUP_MAIN;
      lostCnt_r  <= 8'h00;
    end else if (!cpuHaltState) begin
      unique case (supState_r)
        csrs_pkg::CSRS_SUP_MAIN: begin
          lostCnt_r <= 8'h00;
          if (!mainGood) begin
            supState_r <= csrs_pkg::CSRS_SUP_LOST;
          end
        end
        csrs_pkg::CSRS_SUP_LOST: begin
          if (mainGood) begin
            supState_r <= csrs_pkg::CSRS_SUP_MAIN;
          end else if (enterBackup) begin
            supState_r <= csrs_pkg::CSRS_SUP_BACKUP;
          end else begin
            lostCnt_r <= lostCnt_r + 8'h01;
          end
        end
        csrs_pkg::CSRS_SUP_BACKUP: begin
          lostCnt_r <= 8'h00;
          if (mainGood) begin
            supState_r <= csrs_pkg::CSRS_SUP_MAIN;
          end
        end
        default: begin
          supState_r <= csrs_pkg::CSRS_SUP_MAIN;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      backupClkSelect_r <= 1'b0;
    end else begin
      backupClkSelect_r <= supActive & (enterBackup |
        ((supState_r == csrs_pkg::CSRS_SUP_BACKUP) & ~mainGood));
    end
  end

  // ==========================================================
  // AXI4-Lite write path: address and data taken in either order
  logic [7:0]  wrAddr_r;
  logic [31:0] wrData_r;
  logic [3:0]  wrStrb_r;
  logic        wrAddrHeld_r;
  logic        wrDataHeld_r;
  logic        rdFire;
  logic        rdStatus;

  wire logic   wrFire   = wrAddrHeld_r & wrDataHeld_r & ~s_axi_bvalid;
  wire logic   wrStatus = wrFire & (wrAddr_r == `CSRS_STATUS_ADDR) & wrStrb_r[0];
  wire logic   wrMisc   = wrFire & (wrAddr_r == `CSRS_MISC1_ADDR) & wrStrb_r[0];

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      wrAddrHeld_r  <= 1'b0;
      wrDataHeld_r  <= 1'b0;
      wrAddr_r      <= 8'h00;
      wrData_r      <= 32'h0000_0000;
      wrStrb_r      <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `CSRS_RESP_OKAY;
    end else begin
      s_axi_awready <= ~wrAddrHeld_r & ~s_axi_awready & s_axi_awvalid;
      s_axi_wready  <= ~wrDataHeld_r & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        wrAddrHeld_r <= 1'b1;
        wrAddr_r     <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wrDataHeld_r <= 1'b1;
        wrData_r     <= s_axi_wdata;
        wrStrb_r     <= s_axi_wstrb;
      end
      if (wrFire) begin
        wrAddrHeld_r <= 1'b0;
        wrDataHeld_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= ((wrAddr_r == `CSRS_STATUS_ADDR) || (wrAddr_r == `CSRS_MISC1_ADDR))
                        ? `CSRS_RESP_OKAY : `CSRS_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Status register bits
  logic supplyFlag_r;
  logic wdgFlag_r;
  logic backupFlag_r;
  logic irqEnable_r;

  // A zero write or supply detection off clears: other resets leave the cause visible
  always_ff @(posedge ref_clk) begin
    if (srst || !supplyDetEnSync) begin
      supplyFlag_r <= 1'b0;
    end else if (dropEvt) begin
      supplyFlag_r <= 1'b1;
    end else if (wrStatus && !wrData_r[`CSRS_ST_SUPPLY_BIT]) begin
      supplyFlag_r <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      wdgFlag_r <= 1'b0;
    end else if (wdgEvt) begin
      wdgFlag_r <= 1'b1;
    end else if (dropEvt || (wrStatus && !wrData_r[`CSRS_ST_WDG_BIT])) begin
      wdgFlag_r <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      irqEnable_r <= 1'b0;
    end else if (wrStatus && !cpuHaltState) begin
      irqEnable_r <= wrData_r[`CSRS_ST_IRQEN_BIT];
    end
  end

  // Switch-over beats a clearing read in the same cycle
  always_ff @(posedge ref_clk) begin
    if (srst || !supEnSync) begin
      backupFlag_r <= 1'b0;
    end else if (!cpuHaltState) begin
      if (enterBackup) begin
        backupFlag_r <= 1'b1;
      end else if (rdStatus && supState_r == csrs_pkg::CSRS_SUP_MAIN) begin
        backupFlag_r <= 1'b0;
      end
    end
  end

  logic [7:0] statusView;
  always_comb begin
    statusView                      = 8'h00;
    statusView[`CSRS_ST_SUPPLY_BIT] = supplyFlag_r;
    statusView[`CSRS_ST_IRQEN_BIT]  = irqEnable_r;
    statusView[`CSRS_ST_BACKUP_BIT] = backupFlag_r;
    statusView[`CSRS_ST_WDG_BIT]    = wdgFlag_r;
  end

  // ==========================================================
  // First miscellaneous control register
  logic [4:0] misc1_r;
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      misc1_r <= `CSRS_MISC1_RESET;
    end else if (wrMisc) begin
      misc1_r <= wrData_r[4:0];
    end
  end

  // ==========================================================
  // AXI4-Lite read path
  assign rdFire   = s_axi_arvalid & s_axi_arready;
  assign rdStatus = rdFire & (s_axi_araddr == `CSRS_STATUS_ADDR);

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `CSRS_RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_rvalid & ~s_axi_arready & s_axi_arvalid;
      if (rdFire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `CSRS_RESP_OKAY;
        if (s_axi_araddr == `CSRS_STATUS_ADDR) begin
          s_axi_rdata <= {24'h000000, statusView};
        end else if (s_axi_araddr == `CSRS_MISC1_ADDR) begin
          s_axi_rdata <= {27'h0000000, misc1_r};
        end else begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= `CSRS_RESP_SLVERR;
        end
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Clock-fail interrupt and wake
  wire logic irqCause = backupFlag_r & irqEnable_r & supActive;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      clkFailIrq_r  <= 1'b0;
      clkFailWake_r <= 1'b0;
    end else begin
      clkFailIrq_r  <= irqCause & ~cpuIntMask;
      // Halt stops supervision, so this source can never end a halt
      clkFailWake_r <= irqCause & cpuWaitState & ~cpuHaltState;
    end
  end

  // ==========================================================
  // Prescaler and clock output
  csrs_prescaler u_prescaler (
    .ref_clk    (ref_clk),
    .srst       (srst),
    .slowMode   (misc1_r[`CSRS_MC_SLOW_BIT]),
    .slowDivSel ({misc1_r[`CSRS_MC_DIVHI_BIT], misc1_r[`CSRS_MC_DIVLO_BIT]}),
    .cpuClk     (cpuClk),
    .cpuTick    (cpuClkTick)
  );

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      clkOutPin_r   <= 1'b0;
      clkOutPinOe_r <= 1'b0;
    end else begin
      clkOutPin_r   <= misc1_r[`CSRS_MC_CLKOUT_BIT] & cpuClk;
      clkOutPinOe_r <= misc1_r[`CSRS_MC_CLKOUT_BIT];
    end
  end

endmodule : csrs_clock_security

// file: sim/csrs_clock_security_asserts.sv
// Port-level checker for the clock security block
module csrs_clock_security_asserts (
  // Clock and reset
  input wire logic       ref_clk,
  input wire logic       srst,
  // Register bus handshakes
  input wire logic       s_axi_awvalid,
  input wire logic       s_axi_awready,
  input wire logic       s_axi_wvalid,
  input wire logic       s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_bready,
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic       s_axi_rvalid,
  input wire logic       s_axi_rready,
  // Options, sense pins and CPU state
  input wire logic       optSupervisionEn,
  input wire logic       mainClkPresent,
  input wire logic       mainClkHarmonic,
  input wire logic       cpuIntMask,
  input wire logic       cpuHaltState,
  // Clock outputs
  input wire logic       backupClkSelect_r,
  input wire logic       clkFailIrq_r,
  input wire logic       cpuClk,
  input wire logic       cpuClkTick,
  input wire logic       clkOutPin_r,
  input wire logic       clkOutPinOe_r
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================================
  // Helpers
  logic mainGood;
  assign mainGood = mainClkPresent && !mainClkHarmonic;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (srst);
  // ==========================================================
  // Bus sequences and properties
  sequence s_wr_offer;
    s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  endsequence
  sequence s_wr_taken;
    s_axi_awready && s_axi_wready;
  endsequence
  property p_wr_resp;
    s_wr_offer ##1 s_wr_taken |=> ##1 s_axi_bvalid;
  endproperty
  property p_rd_resp;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid;
  endproperty
  a_wr_resp: assert property (p_wr_resp) else $error("write answer not three cycles on");
  a_rd_resp: assert property (p_rd_resp) else $error("read data not one cycle after take");
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped early");
  a_r_hold: assert property (p_r_hold) else $error("read answer dropped early");
  // ==========================================================
  // Supervision and clock properties
  property p_backup_delay;
    $rose(backupClkSelect_r) |-> !$past(mainGood, 150);
  endproperty
  property p_recover;
    mainGood [*8] |-> !backupClkSelect_r;
  endproperty
  property p_sup_off;
    !optSupervisionEn [*6] |-> !backupClkSelect_r && !clkFailIrq_r;
  endproperty
  property p_irq_gate;
    clkFailIrq_r |-> !$past(cpuIntMask) && !$past(cpuHaltState);
  endproperty
  property p_halt;
    backupClkSelect_r |-> !$past(cpuHaltState);
  endproperty
  property p_clkout;
    clkOutPinOe_r && $past(clkOutPinOe_r) |-> clkOutPin_r == $past(cpuClk);
  endproperty
  property p_tick;
    cpuClkTick |=> !cpuClkTick;
  endproperty
  a_backup_delay: assert property (p_backup_delay) else $error("backup taken too soon");
  a_recover: assert property (p_recover) else $error("backup kept after recovery");
  a_sup_off: assert property (p_sup_off) else $error("backup with supervision off");
  a_irq_gate: assert property (p_irq_gate) else $error("request while masked");
  a_halt: assert property (p_halt) else $error("backup active in halt");
  a_clkout: assert property (p_clkout) else $error("clock pin not following");
  a_tick: assert property (p_tick) else $error("tick longer than a cycle");
endmodule : csrs_clock_security_asserts

bind csrs_clock_security csrs_clock_security_asserts u_asserts (
  .ref_clk, .srst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rready, .optSupervisionEn, .mainClkPresent, .mainClkHarmonic,
  .cpuIntMask, .cpuHaltState, .backupClkSelect_r, .clkFailIrq_r, .cpuClk, .cpuClkTick,
  .clkOutPin_r, .clkOutPinOe_r
);

// file: sim/csrs_clock_source.sv
// Behavioural main clock source as seen on the block's sense pins
module csrs_clock_source (
  // Clock
  input  wire logic       ref_clk,
  // Fault choice: 0 good, 1 stopped, 2 running at a harmonic
  input  wire logic [1:0] faultMode,
  // Sense pins
  output logic            mainClkPresent,
  output logic            mainClkHarmonic
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    mainClkPresent = 1'b1;
    mainClkHarmonic = 1'b0;
  end
  // A harmonic still toggles, so presence stays high while it misbehaves
  always @(posedge ref_clk) begin
    mainClkPresent <= (faultMode != 2'h1);
    mainClkHarmonic <= (faultMode == 2'h2);
  end
endmodule : csrs_clock_source

// file: sim/testbench.sv
// Self-checking bench of the clock security block
`include "csrs_defines.svh"
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk, srst, s_axi_awvalid, s_axi_wvalid, s_axi_bvalid, s_axi_bready;
  logic s_axi_awready, s_axi_wready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic s_axi_rready, optSupervisionEn, optSupplyDetEn, mainClkPresent, mainClkHarmonic;
  logic supplyDropReset, watchdogReset, cpuIntMask, cpuWaitState, cpuHaltState;
  logic resonatorRun_r, clkFilterActive_r, backupClkSelect_r, clkFailIrq_r, clkFailWake_r;
  logic cpuClk, cpuClkTick, clkOutPin_r, clkOutPinOe_r;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, faultMode;
  logic [2:0] optOscSel, oscSource_r;
  int n_fail = 0;
  int samples_checked = 0;
  localparam logic [7:0] ST = `CSRS_STATUS_ADDR;
  localparam logic [7:0] MC = `CSRS_MISC1_ADDR;
  localparam logic [1:0] OK = `CSRS_RESP_OKAY;

  csrs_clock_security dut (.*);
  csrs_clock_source u_src (.ref_clk, .faultMode, .mainClkPresent, .mainClkHarmonic);

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  // ==========================================================
  // Common tasks
  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : final_report
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic give_up(input string nm);
    check(nm, 32'h0, 32'h1);
    final_report();
  endtask : give_up
  task automatic tick(input int k);
    repeat (k) @(posedge ref_clk);
  endtask : tick
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge ref_clk);
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 40);
    s_axi_bready <= 1'b0;
    if (n >= 40) give_up("write answer");
    check("bresp", s_axi_bresp, er);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    int n;
    @(posedge ref_clk);
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 40);
    s_axi_rready <= 1'b0;
    if (n >= 40) give_up("read answer");
    check("rresp", s_axi_rresp, er);
    if (er == OK) check("rdata", s_axi_rdata, exp);
  endtask : rd
  // ==========================================================
  // Scenarios
  task automatic do_reset(input logic [2:0] opt);
    srst <= 1'b1;
    optOscSel <= opt;
    tick(5);
    check("oscSource", oscSource_r, opt);
    check("resonatorRun", resonatorRun_r, opt < 3'h4);
    srst <= 1'b0;
    tick(2);
  endtask : do_reset
  task automatic test_regs();
    rd(ST, 32'h00, OK);
    rd(MC, 32'h00, OK);
    wr(ST, 32'hFF, OK);
    rd(ST, 32'h04, OK);
    wr(8'h10, 32'hFF, `CSRS_RESP_SLVERR);
    rd(8'h10, 32'h0, `CSRS_RESP_SLVERR);
  endtask : test_regs
  task automatic pulse(input logic wdg);
    if (wdg) watchdogReset <= 1'b1;
    else supplyDropReset <= 1'b1;
    tick(3);
    watchdogReset <= 1'b0;
    supplyDropReset <= 1'b0;
    tick(6);
  endtask : pulse
  task automatic test_flags();
    pulse(1'b1);
    rd(ST, 32'h05, OK);
    pulse(1'b0);
    rd(ST, 32'h14, OK);
    pulse(1'b1);
    rd(ST, 32'h15, OK);
    wr(ST, 32'h14, OK);
    rd(ST, 32'h14, OK);
    wr(ST, 32'h04, OK);
    rd(ST, 32'h04, OK);
    pulse(1'b0);
    optSupplyDetEn <= 1'b0;
    tick(4);
    rd(ST, 32'h04, OK);
    optSupplyDetEn <= 1'b1;
  endtask : test_flags
  task automatic period(input int exp);
    int n;
    int p;
    tick(70);
    n = 0;
    while (cpuClkTick !== 1'b1 && n < 100) begin
      @(posedge ref_clk);
      n++;
    end
    if (n >= 100) give_up("tick start");
    p = 0;
    do begin
      @(posedge ref_clk);
      p++;
    end while (cpuClkTick !== 1'b1 && p < 100);
    if (p >= 100) give_up("tick");
    check("cpuClk period", p, exp);
  endtask : period
  task automatic test_prescaler();
    for (int s = 0; s < 4; s++) begin
      wr(MC, (s << 3) | 32'h03, OK);
      period(4 << s);
      check("clkOutPinOe", clkOutPinOe_r, 1'b1);
    end
    wr(MC, 32'h18, OK);
    period(2);
    check("clkOutPinOe", clkOutPinOe_r, 1'b0);
  endtask : test_prescaler
  task automatic test_loss();
    int n;
    n = 0;
    cpuWaitState <= 1'b1;
    faultMode <= 2'h1;
    while (backupClkSelect_r !== 1'b1 && n < 400) begin
      @(posedge ref_clk);
      n++;
    end
    if (n >= 400) give_up("backup select");
    check("backup delay", n >= 160 && n <= 170, 1'b1);
    tick(2);
    check("clkFailIrq", clkFailIrq_r, 1'b1);
    check("clkFailWake", clkFailWake_r, 1'b1);
    cpuIntMask <= 1'b1;
    tick(2);
    check("masked irq", clkFailIrq_r, 1'b0);
    cpuIntMask <= 1'b0;
    cpuWaitState <= 1'b0;
    cpuHaltState <= 1'b1;
    tick(2);
    check("halt backup", backupClkSelect_r, 1'b0);
    check("halt irq", clkFailIrq_r, 1'b0);
    cpuHaltState <= 1'b0;
    rd(ST, 32'h06, OK);
    rd(ST, 32'h06, OK);
    faultMode <= 2'h0;
    tick(8);
    check("recovered", backupClkSelect_r, 1'b0);
    rd(ST, 32'h06, OK);
    rd(ST, 32'h04, OK);
  endtask : test_loss
  task automatic test_filter_off();
    faultMode <= 2'h2;
    tick(6);
    check("filter on", clkFilterActive_r, 1'b1);
    faultMode <= 2'h0;
    tick(6);
    check("filter off", clkFilterActive_r, 1'b0);
    optSupervisionEn <= 1'b0;
    faultMode <= 2'h1;
    tick(200);
    check("off backup", backupClkSelect_r, 1'b0);
    check("off irq", clkFailIrq_r, 1'b0);
    rd(ST, 32'h04, OK);
    faultMode <= 2'h0;
    optSupervisionEn <= 1'b1;
    tick(10);
  endtask : test_filter_off
  // ==========================================================
  // Main sequence
  initial begin
    {srst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {supplyDropReset, watchdogReset, cpuIntMask, cpuWaitState, cpuHaltState} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, faultMode, optOscSel} = '0;
    s_axi_wstrb = 4'hF;
    optSupervisionEn = 1'b1;
    optSupplyDetEn = 1'b1;
    do_reset(3'h2);
    test_regs();
    test_flags();
    test_prescaler();
    test_loss();
    test_filter_off();
    do_reset(3'h5);
    final_report();
  end
endmodule : testbench
